// ==== orn_cfg.svh ====
// Constants for the overrange and preset-select register bank.
`ifndef ORN_CFG_SVH
`define ORN_CFG_SVH
`define ORN_ADDR_THR_HIGH 10'h211
`define ORN_ADDR_THR_LOW 10'h212
`define ORN_ADDR_PIN_CFG 10'h213
`define ORN_ADDR_SRC_MODE 10'h214
`define ORN_ADDR_SELECT 10'h215
`define ORN_ADDR_BINDING 10'h216
`define ORN_ADDR_FREQ_A 10'h220
`define ORN_ADDR_FREQ_B 10'h240
`define ORN_ADDR_IRQ_STATUS 10'h2b0
`define ORN_ADDR_IRQ_MASK 10'h2b1
`define ORN_RST_THR_HIGH 8'hf2
`define ORN_RST_THR_LOW 8'hab
`define ORN_RST_PIN_CFG 8'h07
`define ORN_RST_SRC_MODE 8'h00
`define ORN_RST_SELECT 8'h00
`define ORN_RST_BINDING 8'h02
`define ORN_RST_FREQ 32'hc0000000
`define ORN_RST_PHASE 16'h0000
`define ORN_BIT_PIN_EN 3
`define ORN_MIN_PULSE_BASE 8
`define ORN_PRESETS 4
`endif

// ==== orn_pkg.sv ====
// Types for the overrange and preset-select register bank.
`default_nettype none
package orn_pkg;
  typedef enum logic [1:0] {
    orn_src_register,
    orn_src_pins_split,
    orn_src_pins_shared,
    orn_src_reserved
  } orn_src_t;
endpackage : orn_pkg
`default_nettype wire

// ==== orn_det_if.sv ====
// Interface carrying one channel's detector thresholds, samples and flags.
`default_nettype none
interface orn_det_if #(parameter int SW = 12);
  logic [SW-1:0] sample;
  logic sample_valid;
  logic [7:0] thr_high;
  logic [7:0] thr_low;
  logic [2:0] exponent;
  logic flag_high;
  logic flag_low;
  logic pin_high;
  logic pin_low;
  modport ctrl (output sample, sample_valid, thr_high, thr_low, exponent,
                input flag_high, flag_low, pin_high, pin_low);
  modport det (input sample, sample_valid, thr_high, thr_low, exponent,
               output flag_high, flag_low, pin_high, pin_low);
endinterface : orn_det_if
`default_nettype wire

// ==== orn_detector.sv ====
// One channel's two overrange comparators with pulse stretching.
`default_nettype none
`include "orn_cfg.svh"
module orn_detector
  import orn_pkg::*;
#(
  parameter int SW = 12
) (
  input wire logic clk_i, // Device clock.
  input wire logic rst_i, // Asynchronous reset, active high.
  orn_det_if.det d // Channel detector signals.
);
  // The threshold is padded with SW-9 zeros, so narrower samples cannot be served.
  if (SW < 10 || SW > 24) begin : g_bad_sw
    $error("orn_detector: SW out of range");
  end
  localparam int CW = 11;
  logic [SW-2:0] mag;
  logic [SW-1:0] lim_high;
  logic [SW-1:0] lim_low;
  logic [CW-1:0] cnt_high;
  logic [CW-1:0] cnt_low;
  logic [CW-1:0] period;
  // Two's complement magnitude, saturated so the most negative code reads as full scale.
  always_comb begin
    if (d.sample[SW-1]) begin
      mag = (d.sample[SW-2:0] == '0) ? '1 : (SW-1)'(~d.sample[SW-2:0] + 1'b1);
    end else begin
      mag = d.sample[SW-2:0];
    end
  end
  // Threshold T over 256 of full scale, placed on the magnitude's top bits.
  assign lim_high = SW'({d.thr_high, {(SW-9){1'b0}}});
  assign lim_low = SW'({d.thr_low, {(SW-9){1'b0}}});
  assign d.flag_high = d.sample_valid && ({1'b0, mag} >= lim_high);
  assign d.flag_low = d.sample_valid && ({1'b0, mag} >= lim_low);
  assign period = CW'(`ORN_MIN_PULSE_BASE) << d.exponent;
  // A new hit reloads the count, so the pin stays high for the whole period after it.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_high <= '0;
    end else if (d.flag_high) begin
      cnt_high <= period;
    end else if (cnt_high != '0) begin
      cnt_high <= cnt_high - 1'b1;
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_low <= '0;
    end else if (d.flag_low) begin
      cnt_low <= period;
    end else if (cnt_low != '0) begin
      cnt_low <= cnt_low - 1'b1;
    end
  end
  assign d.pin_high = (cnt_high != '0);
  assign d.pin_low = (cnt_low != '0);
endmodule : orn_detector
`default_nettype wire

// ==== orn_preset_mux.sv ====
// Active preset index selection for both converters.
`default_nettype none
`include "orn_cfg.svh"
module orn_preset_mux
  import orn_pkg::*;
(
  input wire logic [1:0] mode_i, // Preset source mode.
  input wire logic [3:0] select_i, // Register select fields.
  input wire logic [1:0] pins_a_i, // Converter A select pins.
  input wire logic [1:0] pins_b_i, // Converter B select pins.
  output logic [1:0] idx_a_o, // Active preset for converter A.
  output logic [1:0] idx_b_o // Active preset for converter B.
);
  always_comb begin
    case (orn_src_t'(mode_i))
      orn_src_register: begin
        idx_a_o = select_i[1:0];
        idx_b_o = select_i[3:2];
      end
      orn_src_pins_split: begin
        idx_a_o = pins_a_i;
        idx_b_o = pins_b_i;
      end
      orn_src_pins_shared: begin
        idx_a_o = pins_a_i;
        idx_b_o = pins_a_i;
      end
      default: begin
        // Reserved mode falls back to register select so the NCO never sees garbage.
        idx_a_o = select_i[1:0];
        idx_b_o = select_i[3:2];
      end
    endcase
  end
endmodule : orn_preset_mux
`default_nettype wire

// ==== orn_top.sv ====
// Top of the overrange and preset-select register bank.
`default_nettype none
`include "orn_cfg.svh"
module orn_top
  import orn_pkg::*;
#(
  parameter int SW = 12
) (
  input wire logic clk_i, // Device clock, 10 MHz.
  input wire logic rst_i, // Asynchronous reset, active high.
  input wire logic [9:0] addr_i, // Register address.
  input wire logic [7:0] wdata_i, // Write data.
  input wire logic wr_i, // Write strobe.
  input wire logic rd_i, // Read strobe.
  output logic [7:0] rdata_o, // Read data, one cycle after the strobe.
  input wire logic [SW-1:0] sample_a_i, // Channel A sample, two's complement.
  input wire logic [SW-1:0] sample_b_i, // Channel B sample, two's complement.
  input wire logic sample_valid_i, // Samples valid this cycle.
  input wire logic [1:0] preset_pins_conv_a_i, // Converter A preset pins.
  input wire logic [1:0] preset_pins_conv_b_i, // Converter B preset pins.
  output logic overrange_pin_a_high_o, // Channel A high threshold pin.
  output logic overrange_pin_a_low_o, // Channel A low threshold pin.
  output logic overrange_pin_b_high_o, // Channel B high threshold pin.
  output logic overrange_pin_b_low_o, // Channel B low threshold pin.
  output logic [3:0] sample_status_o, // Unstretched flags for the data path.
  output logic [1:0] preset_idx_a_o, // Active preset index A.
  output logic [1:0] preset_idx_b_o, // Active preset index B.
  output logic [31:0] nco_freq_word_conv_a_o, // Active frequency word A.
  output logic [15:0] nco_phase_word_conv_a_o, // Active phase word A.
  output logic [31:0] nco_freq_word_conv_b_o, // Active frequency word B.
  output logic [15:0] nco_phase_word_conv_b_o, // Active phase word B.
  output logic [7:0] channel_binding_o, // Channel binding register.
  output logic irq_o // Level interrupt.
);
  // ==========================================================================
  // Registers
  logic [7:0] overrange_threshold_high;
  logic [7:0] overrange_threshold_low;
  logic [7:0] overrange_pin_config;
  logic [7:0] preset_source_mode;
  logic [7:0] preset_select;
  logic [7:0] channel_binding;
  logic [3:0] irq_status;
  logic [3:0] irq_mask;
  logic [31:0] freq_a [`ORN_PRESETS];
  logic [15:0] phase_a [`ORN_PRESETS];
  logic [31:0] freq_b [`ORN_PRESETS];
  logic [15:0] phase_b [`ORN_PRESETS];
  logic [1:0] idx_a;
  logic [1:0] idx_b;
  logic [3:0] flags;
  logic pin_en;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      overrange_threshold_high <= `ORN_RST_THR_HIGH;
      overrange_threshold_low <= `ORN_RST_THR_LOW;
      overrange_pin_config <= `ORN_RST_PIN_CFG;
      preset_source_mode <= `ORN_RST_SRC_MODE;
      preset_select <= `ORN_RST_SELECT;
      channel_binding <= `ORN_RST_BINDING;
      irq_mask <= 4'h0;
    end else if (wr_i) begin
      if (addr_i == `ORN_ADDR_THR_HIGH) begin
        overrange_threshold_high <= wdata_i;
      end else if (addr_i == `ORN_ADDR_THR_LOW) begin
        overrange_threshold_low <= wdata_i;
      end else if (addr_i == `ORN_ADDR_PIN_CFG) begin
        overrange_pin_config <= wdata_i;
      end else if (addr_i == `ORN_ADDR_SRC_MODE) begin
        preset_source_mode <= wdata_i;
      end else if (addr_i == `ORN_ADDR_SELECT) begin
        preset_select <= wdata_i;
      end else if (addr_i == `ORN_ADDR_BINDING) begin
        channel_binding <= wdata_i;
      end else if (addr_i == `ORN_ADDR_IRQ_MASK) begin
        irq_mask <= wdata_i[3:0];
      end
    end
  end

  // ==========================================================================
  // Preset storage: eight addresses per preset, four frequency bytes then two phase bytes.
  genvar g;
  generate
    for (g = 0; g < `ORN_PRESETS; g++) begin : g_preset
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          freq_a[g] <= `ORN_RST_FREQ;
          phase_a[g] <= `ORN_RST_PHASE;
          freq_b[g] <= `ORN_RST_FREQ;
          phase_b[g] <= `ORN_RST_PHASE;
        end else if (wr_i) begin
          for (int k = 0; k < 4; k++) begin
            if (addr_i == 10'(`ORN_ADDR_FREQ_A + 8 * g + k)) begin
              freq_a[g][8*k +: 8] <= wdata_i;
            end
            if (addr_i == 10'(`ORN_ADDR_FREQ_B + 8 * g + k)) begin
              freq_b[g][8*k +: 8] <= wdata_i;
            end
          end
          for (int k = 0; k < 2; k++) begin
            if (addr_i == 10'(`ORN_ADDR_FREQ_A + 8 * g + 4 + k)) begin
              phase_a[g][8*k +: 8] <= wdata_i;
            end
            if (addr_i == 10'(`ORN_ADDR_FREQ_B + 8 * g + 4 + k)) begin
              phase_b[g][8*k +: 8] <= wdata_i;
            end
          end
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Overrange detectors, one per channel.
  orn_det_if #(.SW(SW)) det_a ();
  orn_det_if #(.SW(SW)) det_b ();
  assign det_a.sample = sample_a_i;
  assign det_b.sample = sample_b_i;
  assign det_a.sample_valid = sample_valid_i;
  assign det_b.sample_valid = sample_valid_i;
  assign det_a.thr_high = overrange_threshold_high;
  assign det_b.thr_high = overrange_threshold_high;
  assign det_a.thr_low = overrange_threshold_low;
  assign det_b.thr_low = overrange_threshold_low;
  // Changing the exponent mid-stream only retimes stretching; software keeps it still.
  assign det_a.exponent = overrange_pin_config[2:0];
  assign det_b.exponent = overrange_pin_config[2:0];

  orn_detector #(.SW(SW)) u_det_a (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d(det_a)
  );
  orn_detector #(.SW(SW)) u_det_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d(det_b)
  );

  assign flags = {det_b.flag_low, det_b.flag_high, det_a.flag_low, det_a.flag_high};
  assign pin_en = overrange_pin_config[`ORN_BIT_PIN_EN];

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      overrange_pin_a_high_o <= 1'b0;
      overrange_pin_a_low_o <= 1'b0;
      overrange_pin_b_high_o <= 1'b0;
      overrange_pin_b_low_o <= 1'b0;
      sample_status_o <= 4'h0;
    end else begin
      overrange_pin_a_high_o <= pin_en & det_a.pin_high;
      overrange_pin_a_low_o <= pin_en & det_a.pin_low;
      overrange_pin_b_high_o <= pin_en & det_b.pin_high;
      overrange_pin_b_low_o <= pin_en & det_b.pin_low;
      sample_status_o <= flags;
    end
  end

  // ==========================================================================
  // Interrupts: a new hit wins over a write-one-to-clear in the same cycle.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_status <= 4'h0;
    end else begin
      if (wr_i && addr_i == `ORN_ADDR_IRQ_STATUS) begin
        irq_status <= (irq_status & ~wdata_i[3:0]) | flags;
      end else begin
        irq_status <= irq_status | flags;
      end
    end
  end
  assign irq_o = |(irq_status & ~irq_mask);

  // ==========================================================================
  // Preset selection.
  orn_preset_mux u_mux (
    .mode_i(preset_source_mode[1:0]),
    .select_i(preset_select[3:0]),
    .pins_a_i(preset_pins_conv_a_i),
    .pins_b_i(preset_pins_conv_b_i),
    .idx_a_o(idx_a),
    .idx_b_o(idx_b)
  );

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      preset_idx_a_o <= 2'h0;
      preset_idx_b_o <= 2'h0;
      nco_freq_word_conv_a_o <= `ORN_RST_FREQ;
      nco_phase_word_conv_a_o <= `ORN_RST_PHASE;
      nco_freq_word_conv_b_o <= `ORN_RST_FREQ;
      nco_phase_word_conv_b_o <= `ORN_RST_PHASE;
    end else begin
      preset_idx_a_o <= idx_a;
      preset_idx_b_o <= idx_b;
      nco_freq_word_conv_a_o <= freq_a[idx_a];
      nco_phase_word_conv_a_o <= phase_a[idx_a];
      nco_freq_word_conv_b_o <= freq_b[idx_b];
      nco_phase_word_conv_b_o <= phase_b[idx_b];
    end
  end
  assign channel_binding_o = channel_binding;

  // ==========================================================================
  // Read port: data in the cycle after the strobe, zero for unmapped addresses.
  logic [7:0] next_rdata;
  logic [2:0] pk;
  logic [1:0] pp;
  logic [1:0] pb;
  always_comb begin
    next_rdata = 8'h00;
    pk = addr_i[2:0];
    pp = addr_i[4:3];
    pb = addr_i[1:0];
    if (addr_i == `ORN_ADDR_THR_HIGH) begin
      next_rdata = overrange_threshold_high;
    end else if (addr_i == `ORN_ADDR_THR_LOW) begin
      next_rdata = overrange_threshold_low;
    end else if (addr_i == `ORN_ADDR_PIN_CFG) begin
      next_rdata = overrange_pin_config;
    end else if (addr_i == `ORN_ADDR_SRC_MODE) begin
      next_rdata = preset_source_mode;
    end else if (addr_i == `ORN_ADDR_SELECT) begin
      next_rdata = preset_select;
    end else if (addr_i == `ORN_ADDR_BINDING) begin
      next_rdata = channel_binding;
    end else if (addr_i == `ORN_ADDR_IRQ_STATUS) begin
      next_rdata = {4'h0, irq_status};
    end else if (addr_i == `ORN_ADDR_IRQ_MASK) begin
      next_rdata = {4'h0, irq_mask};
    end else if (addr_i >= `ORN_ADDR_FREQ_A && addr_i < `ORN_ADDR_FREQ_B) begin
      if (pk < 3'h4) begin
        next_rdata = freq_a[pp][8*pb +: 8];
      end else if (pk < 3'h6) begin
        next_rdata = phase_a[pp][8*pb[0] +: 8];
      end
    end else if (addr_i >= `ORN_ADDR_FREQ_B && addr_i < 10'h260) begin
      if (pk < 3'h4) begin
        next_rdata = freq_b[pp][8*pb +: 8];
      end else if (pk < 3'h6) begin
        next_rdata = phase_b[pp][8*pb[0] +: 8];
      end
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      rdata_o <= next_rdata;
    end else begin
      rdata_o <= 8'h00;
    end
  end
endmodule : orn_top
`default_nettype wire

// ==== orn_host_model.sv ====
// Host logic model: drives the preset pins and watches the overrange pins.
`default_nettype none
module orn_host_model (
  input wire logic clk_i, // Device clock.
  input wire logic rst_i, // Asynchronous reset, active high.
  input wire logic clr_i, // Restart the pulse measurement.
  input wire logic [1:0] req_a_i, // Preset wanted on converter A pins.
  input wire logic [1:0] req_b_i, // Preset wanted on converter B pins.
  input wire logic [3:0] pins_i, // Overrange pins {b_low,b_high,a_low,a_high}.
  output logic [1:0] preset_pins_conv_a_o, // Converter A preset pins.
  output logic [1:0] preset_pins_conv_b_o, // Converter B preset pins.
  output logic [11:0] high_len_o, // Cycles seen with the channel A high pin up.
  output logic [3:0] seen_o // Pins seen high since the last restart.
);
  // ==========================================================
  // Pin drive and pulse measurement
  // The pins are levels the host always drives, so no idle pattern is needed.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      preset_pins_conv_a_o <= 2'h0;
      preset_pins_conv_b_o <= 2'h0;
      high_len_o <= 12'h000;
      seen_o <= 4'h0;
    end else begin
      preset_pins_conv_a_o <= req_a_i;
      preset_pins_conv_b_o <= req_b_i;
      if (clr_i) begin
        high_len_o <= 12'h000;
        seen_o <= 4'h0;
      end else begin
        high_len_o <= high_len_o + {11'h000, pins_i[0]};
        seen_o <= seen_o | pins_i;
      end
    end
  end
endmodule : orn_host_model
`default_nettype wire

// ==== orn_top_chk.sv ====
// Concurrent checks on the ports of the overrange and preset-select bank.
`default_nettype none
`include "orn_cfg.svh"
module orn_top_chk
  import orn_pkg::*;
#(
  parameter int SW = 12
) (
  input wire logic clk_i, // Device clock.
  input wire logic rst_i, // Asynchronous reset, active high.
  input wire logic [9:0] addr_i, // Register address.
  input wire logic [7:0] wdata_i, // Write data.
  input wire logic wr_i, // Write strobe.
  input wire logic rd_i, // Read strobe.
  input wire logic [7:0] rdata_o, // Read data.
  input wire logic [SW-1:0] sample_a_i, // Channel A sample.
  input wire logic [SW-1:0] sample_b_i, // Channel B sample.
  input wire logic sample_valid_i, // Samples valid.
  input wire logic [1:0] preset_pins_conv_a_i, // Converter A pins.
  input wire logic [1:0] preset_pins_conv_b_i, // Converter B pins.
  input wire logic overrange_pin_a_high_o, // Channel A high pin.
  input wire logic overrange_pin_b_low_o, // Channel B low pin.
  input wire logic overrange_pin_a_low_o, // Channel A low pin.
  input wire logic overrange_pin_b_high_o, // Channel B high pin.
  input wire logic [3:0] sample_status_o, // Unstretched flags.
  input wire logic [1:0] preset_idx_a_o, // Active index A.
  input wire logic [1:0] preset_idx_b_o, // Active index B.
  input wire logic [7:0] channel_binding_o, // Binding register.
  input wire logic irq_o // Level interrupt.
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================
  // Register shadows and expected values
  logic [7:0] thr_h, thr_l, cfg, mode, sel, bind_q, mask;
  logic [3:0] hit;
  logic [1:0] exp_a, exp_b;
  logic [11:0] run;
  logic pins_any;
  function automatic logic [SW-2:0] mag(input logic [SW-1:0] s);
    logic [SW-1:0] n;
    n = s[SW-1] ? (~s + 1'b1) : s;
    return n[SW-1] ? {(SW-1){1'b1}} : n[SW-2:0];
  endfunction : mag
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      thr_h <= 8'hf2;
      thr_l <= 8'hab;
      cfg <= 8'h07;
      mode <= 8'h00;
      sel <= 8'h00;
      bind_q <= 8'h02;
      mask <= 8'h00;
    end else if (wr_i) begin
      case (addr_i)
        `ORN_ADDR_THR_HIGH: thr_h <= wdata_i;
        `ORN_ADDR_THR_LOW: thr_l <= wdata_i;
        `ORN_ADDR_PIN_CFG: cfg <= wdata_i;
        `ORN_ADDR_SRC_MODE: mode <= wdata_i;
        `ORN_ADDR_SELECT: sel <= wdata_i;
        `ORN_ADDR_BINDING: bind_q <= wdata_i;
        `ORN_ADDR_IRQ_MASK: mask <= wdata_i;
        default: ;
      endcase
    end
  end
  // Run length restarts on every low cycle, so it measures one whole pulse.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      run <= 12'h000;
    end else if (!overrange_pin_a_high_o) begin
      run <= 12'h000;
    end else if (run != 12'hfff) begin
      run <= run + 12'h001;
    end
  end
  assign hit[0] = sample_valid_i && (mag(sample_a_i) >= {thr_h, {(SW-9){1'b0}}});
  assign hit[1] = sample_valid_i && (mag(sample_a_i) >= {thr_l, {(SW-9){1'b0}}});
  assign hit[2] = sample_valid_i && (mag(sample_b_i) >= {thr_h, {(SW-9){1'b0}}});
  assign hit[3] = sample_valid_i && (mag(sample_b_i) >= {thr_l, {(SW-9){1'b0}}});
  assign pins_any = overrange_pin_a_high_o | overrange_pin_a_low_o | overrange_pin_b_high_o
      | overrange_pin_b_low_o;
  assign exp_a = (mode[1:0] == orn_src_pins_split || mode[1:0] == orn_src_pins_shared)
      ? preset_pins_conv_a_i : sel[1:0];
  assign exp_b = (mode[1:0] == orn_src_pins_split) ? preset_pins_conv_b_i
      : (mode[1:0] == orn_src_pins_shared) ? preset_pins_conv_a_i : sel[3:2];
  // ==========================================================
  // Assertions
  flag_high_a: assert property (
      {sample_status_o[2], sample_status_o[0]} == $past({hit[2], hit[0]}))
    else $error("high flag does not follow the sample");
  flag_low_a: assert property (
      {sample_status_o[3], sample_status_o[1]} == $past({hit[3], hit[1]}))
    else $error("low flag does not follow the sample");
  pins_off_a: assert property (!cfg[3] && !$past(cfg[3]) |-> !pins_any)
    else $error("overrange pin high while disabled");
  pin_hit_a: assert property (hit[0] && cfg[3] |-> ##[1:3] overrange_pin_a_high_o)
    else $error("channel A high pin missed a hit");
  pin_hit_chb_a: assert property (
      hit[3] && cfg[3] |-> ##[1:3] overrange_pin_b_low_o)
    else $error("channel B low pin missed a hit");
  stretch_min_a: assert property ($fell(overrange_pin_a_high_o) && cfg[3] && $past(cfg[3])
      |-> run >= (12'd8 << cfg[2:0]))
    else $error("overrange pulse shorter than the minimum");
  preset_a_a: assert property (preset_idx_a_o == $past(exp_a))
    else $error("wrong active preset for converter A");
  preset_b_a: assert property (preset_idx_b_o == $past(exp_b))
    else $error("wrong active preset for converter B");
  rd_thr_a: assert property (
      rd_i && addr_i == `ORN_ADDR_THR_LOW |=> rdata_o == $past(thr_l))
    else $error("threshold read back wrong");
  bind_reg_a: assert property (channel_binding_o == bind_q)
    else $error("binding register output wrong");
  irq_mask_a: assert property (mask[3:0] == 4'hf && $past(mask[3:0]) == 4'hf |-> !irq_o)
    else $error("masked interrupt still raised");
  pulse_c: cover property ($fell(overrange_pin_a_high_o) && cfg[3]);
  shared_c: cover property (mode[1:0] == orn_src_pins_shared && preset_idx_b_o == 2'h1);
  irq_c: cover property ($rose(irq_o));
endmodule : orn_top_chk
bind orn_top orn_top_chk #(.SW(SW)) orn_top_chk_inst (.*);
`default_nettype wire

// ==== overrange_and_nco_preset_ctrl_tb.sv ====
// Self-checking testbench of the overrange and preset-select bank.
`default_nettype none
`include "orn_cfg.svh"
module overrange_and_nco_preset_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [9:0] addr_i = 10'h000;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [11:0] sample_a_i = 12'h000;
  logic [11:0] sample_b_i = 12'h000;
  logic sample_valid_i = 1'b0;
  logic clr = 1'b1;
  logic [1:0] req_a = 2'h0;
  logic [1:0] req_b = 2'h0;
  logic [7:0] rdata_o, bind_o;
  logic [3:0] pins, status, seen;
  logic [1:0] pa, pb, idx_a, idx_b;
  logic [31:0] fa, fb;
  logic [15:0] ha, hb;
  logic [11:0] len;
  logic irq;
  int err_count = 0;
  int checks_done = 0;
  int cycles = 0;
  always #50 clk_i = ~clk_i;
  orn_top #(.SW(12)) orn_top_inst (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sample_a_i(sample_a_i),
    .sample_b_i(sample_b_i), .sample_valid_i(sample_valid_i), .preset_pins_conv_a_i(pa),
    .preset_pins_conv_b_i(pb), .overrange_pin_a_high_o(pins[0]),
    .overrange_pin_a_low_o(pins[1]), .overrange_pin_b_high_o(pins[2]),
    .overrange_pin_b_low_o(pins[3]), .sample_status_o(status), .preset_idx_a_o(idx_a),
    .preset_idx_b_o(idx_b), .nco_freq_word_conv_a_o(fa), .nco_phase_word_conv_a_o(ha),
    .nco_freq_word_conv_b_o(fb), .nco_phase_word_conv_b_o(hb), .channel_binding_o(bind_o),
    .irq_o(irq));
  orn_host_model orn_host_model_inst (.clk_i(clk_i), .rst_i(rst_i), .clr_i(clr),
    .req_a_i(req_a), .req_b_i(req_b), .pins_i(pins), .preset_pins_conv_a_o(pa),
    .preset_pins_conv_b_o(pb), .high_len_o(len), .seen_o(seen));
  // ==========================================================
  // Bus cycles and comparisons
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected register data at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected port value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk_val
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [9:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk_reg(rdata_o, exp);
  endtask : rd
  // Holds the sample for one cycle; returns once the registered flags are visible.
  task automatic samp(input logic [11:0] a, input logic [11:0] b);
    @(posedge clk_i);
    sample_a_i <= a;
    sample_b_i <= b;
    sample_valid_i <= 1'b1;
    @(posedge clk_i);
    sample_valid_i <= 1'b0;
    #1;
  endtask : samp
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    rd(`ORN_ADDR_THR_HIGH, 8'hf2);
    rd(`ORN_ADDR_THR_LOW, 8'hab);
    rd(`ORN_ADDR_PIN_CFG, 8'h07);
    rd(`ORN_ADDR_SRC_MODE, 8'h00);
    rd(`ORN_ADDR_SELECT, 8'h00);
    rd(`ORN_ADDR_BINDING, 8'h02);
    rd(10'h3ff, 8'h00);
    wr(`ORN_ADDR_BINDING, 8'ha5);
    chk_val({24'h0, bind_o}, 32'ha5);
    rd(`ORN_ADDR_BINDING, 8'ha5);
  endtask : t_reset
  task automatic t_detect();
    logic [11:0] sa [6] = '{12'h790, 12'h78f, 12'h000, 12'h000, 12'h800, 12'h000};
    logic [11:0] sb [6] = '{12'h000, 12'h000, 12'haa8, 12'haa9, 12'h000, 12'h7ff};
    logic [3:0] ex [6] = '{4'h3, 4'h2, 4'h8, 4'h0, 4'h3, 4'hc};
    wr(`ORN_ADDR_PIN_CFG, 8'h08);
    for (int i = 0; i < 6; i++) begin
      samp(sa[i], sb[i]);
      chk_val({28'h0, status}, {28'h0, ex[i]});
    end
  endtask : t_detect
  // Waits for idle pins first, so the stretch length never changes mid-pulse.
  task automatic pulse(input logic [7:0] cfg, input logic [11:0] lmin, input logic [3:0] ex);
    for (int i = 0; i < 2100 && pins !== 4'h0; i++) @(posedge clk_i);
    wr(`ORN_ADDR_PIN_CFG, cfg);
    clr <= 1'b1;
    samp(12'h790, 12'h800);
    clr <= 1'b0;
    chk_val({28'h0, status}, 32'hf);
    for (int i = 0; i < 2100 && (pins !== 4'h0 || i < 4); i++) @(posedge clk_i);
    #1;
    chk_val({31'h0, len >= lmin && len <= lmin + 12'd1}, 32'h1);
    chk_val({28'h0, seen}, {28'h0, ex});
  endtask : pulse
  task automatic t_preset();
    logic [1:0] ea [3] = '{2'h1, 2'h1, 2'h2};
    logic [1:0] eb [3] = '{2'h0, 2'h1, 2'h3};
    logic [7:0] wd [6] = '{8'h78, 8'h56, 8'h34, 8'h12, 8'hef, 8'hbe};
    wr(`ORN_ADDR_SELECT, 8'h0e);
    req_a <= 2'h1;
    // Modes 1, 2, then 0; the reserved mode is never programmed.
    for (int m = 0; m < 3; m++) begin
      wr(`ORN_ADDR_SRC_MODE, 8'((m + 1) % 3));
      repeat (3) @(posedge clk_i);
      #1;
      chk_val({28'h0, idx_b, idx_a}, {28'h0, eb[m], ea[m]});
    end
    for (int i = 0; i < 6; i++) wr(10'h230 + 10'(i), wd[i]);
    repeat (3) @(posedge clk_i);
    #1;
    chk_val(fa, 32'h12345678);
    chk_val({16'h0, ha}, 32'hbeef);
    chk_val(fb, 32'hc0000000);
    chk_val({16'h0, hb}, 32'h00000000);
    wr(`ORN_ADDR_SELECT, 8'h0c);
    repeat (3) @(posedge clk_i);
    #1;
    chk_val(fa, 32'hc0000000);
  endtask : t_preset
  task automatic t_irq();
    wr(`ORN_ADDR_IRQ_MASK, 8'h00);
    wr(`ORN_ADDR_IRQ_STATUS, 8'h0f);
    rd(`ORN_ADDR_IRQ_STATUS, 8'h00);
    samp(12'h790, 12'h000);
    repeat (2) @(posedge clk_i);
    #1;
    chk_val({31'h0, irq}, 32'h1);
    rd(`ORN_ADDR_IRQ_STATUS, 8'h03);
    wr(`ORN_ADDR_IRQ_MASK, 8'h0f);
    chk_val({31'h0, irq}, 32'h0);
    wr(`ORN_ADDR_IRQ_MASK, 8'h00);
    chk_val({31'h0, irq}, 32'h1);
    wr(`ORN_ADDR_IRQ_STATUS, 8'h03);
    chk_val({31'h0, irq}, 32'h0);
    rd(`ORN_ADDR_IRQ_STATUS, 8'h00);
  endtask : t_irq
  task automatic results();
    if (err_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results
  // ==========================================================
  // Main sequence and hang guard
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_detect();
    pulse(8'h08, 12'd8, 4'hf);
    pulse(8'h09, 12'd16, 4'hf);
    pulse(8'h00, 12'd0, 4'h0);
    t_preset();
    t_irq();
    results();
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      results();
    end
  end
endmodule : overrange_and_nco_preset_ctrl_tb
`default_nettype wire
